// ### hw/dcir_pkg.sv
// Purpose: constants for the dual processor interrupt router
// Assumes: 32-bit processor memory writes, one write per cycle
// Notes: offsets are the low 28 bits of the byte address
package dcir_pkg;
	// -------------------------------------------------------------------
	// address map
	// -------------------------------------------------------------------
	localparam logic [27:0] DCIR_OFF_IPI = 28'hfc00000;
	localparam logic [27:0] DCIR_OFF_MASK = 28'hfc00010;
	localparam logic [27:0] DCIR_OFF_TOGGLE = 28'hfc00018;
	localparam logic [27:0] DCIR_OFF_ALTCPU = 28'hfc00028;
	localparam logic [27:0] DCIR_OFF_BASE = 28'hfc00030;
	localparam logic [27:0] DCIR_OFF_MPEN = 28'hfc00038;
	// -------------------------------------------------------------------
	// field positions and reset values
	// -------------------------------------------------------------------
	localparam int DCIR_BIT_D0 = 0;
	localparam int DCIR_BASE_MSB = 3;
	localparam logic [3:0] DCIR_BASE_RST = 4'hf;
	localparam logic DCIR_MASK0_RST = 1'h0;
	localparam logic DCIR_MASK1_RST = 1'h1;
	localparam logic DCIR_TOGGLE_RST = 1'h0;
	localparam logic DCIR_ALTCPU_RST = 1'h0;
	localparam logic DCIR_MPEN_RST = 1'h0;
	// which processor legacy requests go to
	typedef enum logic [0:0] {
		DCIR_TGT_CPU0 = 1'b0,
		DCIR_TGT_CPU1 = 1'b1
	} dcir_target_t;
endpackage

// ### hw/dcir_irq_steer.sv
// Purpose: steer legacy interrupt requests between two processors
// Assumes: requests arrive as one-cycle pulses on clk_sys_i
// Notes: only legacy requests advance the alternation
`timescale 1ns/1ps
`default_nettype none
module dcir_irq_steer (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic legacy_irq_i,
	input wire logic toggle_en_i,
	input wire logic mp_en_i,
	input wire logic [1:0] mask_i,
	output logic [1:0] legacy_irq_o
);
	import dcir_pkg::*;
	dcir_target_t next_tgt_r;
	dcir_target_t next_tgt_nxt;
	logic alt_mode;
	logic [1:0] route;
	// -------------------------------------------------------------------
	// target choice
	// -------------------------------------------------------------------
	// alternation only counts while toggle and multiprocessor are both on
	assign alt_mode = toggle_en_i && mp_en_i;
	assign route[0] = legacy_irq_i && (!alt_mode || next_tgt_r == DCIR_TGT_CPU0) && !mask_i[0];
	assign route[1] = legacy_irq_i && alt_mode && next_tgt_r == DCIR_TGT_CPU1 && !mask_i[1];
	// a masked target still consumes its turn, keeping the sequence fair
	assign next_tgt_nxt = (legacy_irq_i && alt_mode) ?
		((next_tgt_r == DCIR_TGT_CPU0) ? DCIR_TGT_CPU1 : DCIR_TGT_CPU0) : next_tgt_r;
	// state and registered outputs
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			next_tgt_r <= DCIR_TGT_CPU0;
			legacy_irq_o <= 2'h0;
		end else begin
			next_tgt_r <= next_tgt_nxt;
			legacy_irq_o <= route;
		end
	end
	// -------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------
	chk_mask_blocks: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		mask_i[1] |=> !legacy_irq_o[1]) else $error("masked cpu1 got legacy irq");
	chk_fixed_route: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(legacy_irq_i && !toggle_en_i && !mask_i[0]) |=> legacy_irq_o == 2'h1)
		else $error("fixed mode did not route to cpu0");
	chk_alternation: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(legacy_irq_i && alt_mode) |=> next_tgt_r != $past(next_tgt_r))
		else $error("alternation did not advance");
	chk_hold_turn: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		!legacy_irq_i |=> $stable(next_tgt_r)) else $error("turn moved without legacy irq");
	chk_mp_off: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		!mp_en_i |=> !legacy_irq_o[1]) else $error("cpu1 got irq with mp off");
	cov_alt_cpu1: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) legacy_irq_o[1]);
endmodule
`default_nettype wire

// ### hw/dcir_router.sv
// Purpose: memory mapped interrupt router for two processor cores
// Assumes: each core issues a one-cycle write strobe with address and data
// Notes: all registers are write-only; nothing is readable back
`timescale 1ns/1ps
`default_nettype none
// Function
// - dispatch write sends ipi while mp enable is set, data ignored
// - top address nibble matches base register
// - base register is four bits, data 3:0
// - base register resets to all ones
// - per-cpu mask on d0, resets 0/1
// - a cpu writes only its own mask
// - set mask blocks legacy irqs to cpu
// - toggle bit d0, zero routes to cpu0
// - toggle set alternates legacy irq targets while mp enable is set
// - ipi never advances alternation
// - alternate cpu type flag on d0
// - multiprocessor enable on d0, resets 0
module dcir_router (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic cpu0_wr_i,
	input wire logic [31:0] cpu0_addr_i,
	input wire logic [31:0] cpu0_wdata_i,
	input wire logic cpu1_wr_i,
	input wire logic [31:0] cpu1_addr_i,
	input wire logic [31:0] cpu1_wdata_i,
	input wire logic legacy_irq_i,
	output logic [1:0] legacy_irq_o,
	output logic [1:0] ipi_o,
	output logic alt_cpu_type_o,
	output logic mp_enable_o,
	output logic [3:0] base_nibble_o
);
	import dcir_pkg::*;
	logic [3:0] base_nibble_r;
	logic [3:0] base_nibble_nxt;
	logic [1:0] mask_r;
	logic [1:0] mask_nxt;
	logic toggle_r;
	logic toggle_nxt;
	logic alt_cpu_r;
	logic alt_cpu_nxt;
	logic mp_en_r;
	logic mp_en_nxt;
	logic [1:0] ipi_nxt;
	logic [1:0] hit_ipi;
	logic [1:0] hit_mask;
	logic [1:0] hit_toggle;
	logic [1:0] hit_altcpu;
	logic [1:0] hit_base;
	logic [1:0] hit_mpen;
	logic [1:0] wr;
	logic [31:0] addr [2];
	logic [31:0] wdata [2];
	logic [1:0] hit_any;
	logic clash;
	// -------------------------------------------------------------------
	// decode
	// -------------------------------------------------------------------
	// compare an address against a register offset under the current base
	function automatic logic hit(input logic [31:0] a, input logic [3:0] b,
		input logic [27:0] off);
		hit = (a[31:28] == b) && (a[27:0] == off);
	endfunction
	assign wr = {cpu1_wr_i, cpu0_wr_i};
	assign addr[0] = cpu0_addr_i;
	assign addr[1] = cpu1_addr_i;
	assign wdata[0] = cpu0_wdata_i;
	assign wdata[1] = cpu1_wdata_i;
	// per-core hit vectors; shared registers take cpu1 on a same-cycle clash
	for (genvar c = 0; c < 2; c++) begin : g_dec
		assign hit_ipi[c] = wr[c] && hit(addr[c], base_nibble_r, DCIR_OFF_IPI);
		assign hit_mask[c] = wr[c] && hit(addr[c], base_nibble_r, DCIR_OFF_MASK);
		assign hit_toggle[c] = wr[c] && hit(addr[c], base_nibble_r, DCIR_OFF_TOGGLE);
		assign hit_altcpu[c] = wr[c] && hit(addr[c], base_nibble_r, DCIR_OFF_ALTCPU);
		assign hit_base[c] = wr[c] && hit(addr[c], base_nibble_r, DCIR_OFF_BASE);
		assign hit_mpen[c] = wr[c] && hit(addr[c], base_nibble_r, DCIR_OFF_MPEN);
	end
	// one core hit some register of this block; anything else is dropped silently
	assign hit_any = hit_ipi | hit_mask | hit_toggle | hit_altcpu | hit_base | hit_mpen;
	// limitation: only the exact word offsets decode, so a byte write into the
	// middle of a register location is ignored rather than merged
	// both cores wrote one shared register in the same cycle; cpu1 takes it
	assign clash = (hit_toggle[0] && hit_toggle[1]) || (hit_altcpu[0] && hit_altcpu[1]) ||
		(hit_base[0] && hit_base[1]) || (hit_mpen[0] && hit_mpen[1]);
	// -------------------------------------------------------------------
	// next values
	// -------------------------------------------------------------------
	// each core owns one mask bit; the other core's write cannot reach it
	assign mask_nxt[0] = hit_mask[0] ? wdata[0][DCIR_BIT_D0] : mask_r[0];
	assign mask_nxt[1] = hit_mask[1] ? wdata[1][DCIR_BIT_D0] : mask_r[1];
	assign toggle_nxt = hit_toggle[1] ? wdata[1][DCIR_BIT_D0] :
		hit_toggle[0] ? wdata[0][DCIR_BIT_D0] : toggle_r;
	assign alt_cpu_nxt = hit_altcpu[1] ? wdata[1][DCIR_BIT_D0] :
		hit_altcpu[0] ? wdata[0][DCIR_BIT_D0] : alt_cpu_r;
	assign base_nibble_nxt = hit_base[1] ? wdata[1][DCIR_BASE_MSB:0] :
		hit_base[0] ? wdata[0][DCIR_BASE_MSB:0] : base_nibble_r;
	assign mp_en_nxt = hit_mpen[1] ? wdata[1][DCIR_BIT_D0] :
		hit_mpen[0] ? wdata[0][DCIR_BIT_D0] : mp_en_r;
	// ipi goes to the other core; data is never looked at
	assign ipi_nxt = mp_en_r ? {hit_ipi[0], hit_ipi[1]} : 2'h0;
	// -------------------------------------------------------------------
	// registers
	// -------------------------------------------------------------------
	// base nibble; a new value moves the whole window for the next write
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			base_nibble_r <= DCIR_BASE_RST;
		end else begin
			base_nibble_r <= base_nibble_nxt;
		end
	end
	// one mask bit per core, each with its own value after reset
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			mask_r <= {DCIR_MASK1_RST, DCIR_MASK0_RST};
		end else begin
			mask_r <= mask_nxt;
		end
	end
	// routing mode for legacy requests
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			toggle_r <= DCIR_TOGGLE_RST;
		end else begin
			toggle_r <= toggle_nxt;
		end
	end
	// processor type flag is only exported; nothing in here depends on it
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			alt_cpu_r <= DCIR_ALTCPU_RST;
		end else begin
			alt_cpu_r <= alt_cpu_nxt;
		end
	end
	// multiprocessor enable gates both ipi and alternation
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			mp_en_r <= DCIR_MPEN_RST;
		end else begin
			mp_en_r <= mp_en_nxt;
		end
	end
	// ipi lasts one cycle because ipi_nxt only follows a write strobe
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ipi_o <= 2'h0;
		end else begin
			ipi_o <= ipi_nxt;
		end
	end
	assign alt_cpu_type_o = alt_cpu_r;
	assign mp_enable_o = mp_en_r;
	assign base_nibble_o = base_nibble_r;
	// -------------------------------------------------------------------
	// legacy steering
	// -------------------------------------------------------------------
	// ipi has no path into the steering block, so it cannot move the turn
	dcir_irq_steer u_steer (
		.clk_sys_i(clk_sys_i),
		.sys_rst_i(sys_rst_i),
		.legacy_irq_i(legacy_irq_i),
		.toggle_en_i(toggle_r),
		.mp_en_i(mp_en_r),
		.mask_i(mask_r),
		.legacy_irq_o(legacy_irq_o)
	);
	// -------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------
	chk_ipi_send: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_ipi[0] && mp_en_r) |=> ipi_o[1]) else $error("ipi not sent to cpu1");
	chk_base_decode: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(cpu0_wr_i && cpu0_addr_i[31:28] != base_nibble_r) |-> !hit_ipi[0] && !hit_mask[0])
		else $error("decode ignored base nibble");
	chk_base_write: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_base[0] && !hit_base[1]) |=> base_nibble_r == $past(cpu0_wdata_i[3:0]))
		else $error("base write lost");
	chk_base_reset: assert property (@(posedge clk_sys_i)
		$past(sys_rst_i) |-> base_nibble_r == DCIR_BASE_RST) else $error("base reset wrong");
	chk_mask_own: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(!hit_mask[1]) |=> mask_r[1] == $past(mask_r[1])) else $error("cpu1 mask changed");
	chk_mask_reset: assert property (@(posedge clk_sys_i)
		$past(sys_rst_i) |-> mask_r == {DCIR_MASK1_RST, DCIR_MASK0_RST})
		else $error("mask reset wrong");
	chk_altcpu_write: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_altcpu[1]) |=> alt_cpu_r == $past(cpu1_wdata_i[0])) else $error("type flag lost");
	chk_mpen_write: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_mpen[1]) |=> mp_en_r == $past(cpu1_wdata_i[0])) else $error("mp enable lost");
	chk_ipi_mp_off: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		!mp_en_r |=> ipi_o == 2'h0) else $error("ipi with mp off");
	chk_toggle_write: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_toggle[0] && !hit_toggle[1]) |=> toggle_r == $past(cpu0_wdata_i[0]))
		else $error("toggle write lost");
	cov_ipi: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) ipi_o != 2'h0);
	cov_rebase: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		hit_base[0] ##1 hit_ipi[0]);
	cov_toggle_on: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		toggle_r && mp_en_r && legacy_irq_i);
	cov_clash: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) clash);
	// -------------------------------------------------------------------
	// checks: decode and ipi
	// -------------------------------------------------------------------
	// the second core decodes through the same base nibble as the first
	chk_base_decode1: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(cpu1_wr_i && cpu1_addr_i[31:28] != base_nibble_r) |-> !hit_any[1])
		else $error("cpu1 decode ignored base nibble");
	// a write that hits nothing must leave every register alone
	chk_stray_drop: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_any == 2'h0) |=> $stable(base_nibble_r) && $stable(mask_r)
		&& $stable(toggle_r) && $stable(alt_cpu_r) && $stable(mp_en_r))
		else $error("stray write changed a register");
	// an ipi pulse needs a dispatch write in the cycle before
	chk_ipi_quiet: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_ipi == 2'h0) |=> ipi_o == 2'h0)
		else $error("ipi without dispatch write");
	chk_ipi_to_cpu0: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_ipi[1] && mp_en_r) |=> ipi_o[0])
		else $error("ipi not sent to cpu0");
	// a core never interrupts itself through the dispatch register
	chk_ipi_no_self0: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_ipi[0] && !hit_ipi[1]) |=> !ipi_o[0])
		else $error("ipi looped back to cpu0");
	chk_ipi_no_self1: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_ipi[1] && !hit_ipi[0]) |=> !ipi_o[1])
		else $error("ipi looped back to cpu1");
	// crossed dispatch writes in one cycle must both land
	chk_ipi_both: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_ipi == 2'h3 && mp_en_r) |=> ipi_o == 2'h3)
		else $error("crossed ipi lost");
	// -------------------------------------------------------------------
	// checks: register writes
	// -------------------------------------------------------------------
	// each core's own strobe sets its own mask bit from d0
	chk_mask0_write: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		hit_mask[0] |=> mask_r[0] == $past(cpu0_wdata_i[0]))
		else $error("cpu0 mask write lost");
	chk_mask1_write: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		hit_mask[1] |=> mask_r[1] == $past(cpu1_wdata_i[0]))
		else $error("cpu1 mask write lost");
	chk_mask0_own: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		!hit_mask[0] |=> mask_r[0] == $past(mask_r[0]))
		else $error("cpu0 mask changed");
	// on a clash the shared registers take the second core's data
	chk_toggle_win: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		hit_toggle[1] |=> toggle_r == $past(cpu1_wdata_i[0]))
		else $error("toggle clash lost");
	chk_altcpu_cpu0: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_altcpu[0] && !hit_altcpu[1]) |=> alt_cpu_r == $past(cpu0_wdata_i[0]))
		else $error("cpu0 type flag write lost");
	chk_mpen_cpu0: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_mpen[0] && !hit_mpen[1]) |=> mp_en_r == $past(cpu0_wdata_i[0]))
		else $error("cpu0 mp enable write lost");
	chk_base_win: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		hit_base[1] |=> base_nibble_r == $past(cpu1_wdata_i[3:0]))
		else $error("base clash lost");
	// without a hit a shared register keeps its value
	chk_toggle_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_toggle == 2'h0) |=> $stable(toggle_r))
		else $error("toggle changed unasked");
	chk_altcpu_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_altcpu == 2'h0) |=> $stable(alt_cpu_r))
		else $error("type flag changed unasked");
	chk_mpen_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_mpen == 2'h0) |=> $stable(mp_en_r))
		else $error("mp enable changed unasked");
	chk_base_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(hit_base == 2'h0) |=> $stable(base_nibble_r))
		else $error("base changed unasked");
	// -------------------------------------------------------------------
	// checks: reset values
	// -------------------------------------------------------------------
	// looked at on every edge after a reset edge, mid-run resets included
	chk_toggle_reset: assert property (@(posedge clk_sys_i)
		$past(sys_rst_i) |-> toggle_r == DCIR_TOGGLE_RST)
		else $error("toggle reset wrong");
	chk_altcpu_reset: assert property (@(posedge clk_sys_i)
		$past(sys_rst_i) |-> alt_cpu_r == DCIR_ALTCPU_RST)
		else $error("type flag reset wrong");
	chk_mpen_reset: assert property (@(posedge clk_sys_i)
		$past(sys_rst_i) |-> mp_en_r == DCIR_MPEN_RST)
		else $error("mp enable reset wrong");
	chk_ipi_reset: assert property (@(posedge clk_sys_i)
		$past(sys_rst_i) |-> ipi_o == 2'h0)
		else $error("ipi reset wrong");
	chk_legacy_reset: assert property (@(posedge clk_sys_i)
		$past(sys_rst_i) |-> legacy_irq_o == 2'h0)
		else $error("legacy outputs reset wrong");
	// -------------------------------------------------------------------
	// checks: legacy routing at the block edge
	// -------------------------------------------------------------------
	// a masked cpu0 gets nothing, whatever the routing mode
	chk_mask0_blocks: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		mask_r[0] |=> !legacy_irq_o[0])
		else $error("masked cpu0 got legacy irq");
	// with multiprocessor off every unmasked request lands on cpu0
	chk_mp_off_route: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		(legacy_irq_i && !mp_en_r && !mask_r[0]) |=> legacy_irq_o == 2'h1)
		else $error("mp off did not route to cpu0");
	// one request is delivered to one core at most, never copied
	chk_legacy_onehot: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
		legacy_irq_o != 2'h3)
		else $error("legacy irq sent to both cores");
endmodule
`default_nettype wire

// ### tb/dcir_cpu_model.sv
// Purpose: two host cores issuing single memory writes to the router
// Assumes: one strobe cycle per write, launched 1 ns after a rising edge
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module dcir_cpu_model (
	input wire logic clk_sys_i,
	output logic cpu0_wr_o,
	output logic [31:0] cpu0_addr_o,
	output logic [31:0] cpu0_wdata_o,
	output logic cpu1_wr_o,
	output logic [31:0] cpu1_addr_o,
	output logic [31:0] cpu1_wdata_o
);
	logic wr_q [2] = '{1'b0, 1'b0};
	logic [31:0] a_q [2] = '{32'h0, 32'h0};
	logic [31:0] d_q [2] = '{32'h0, 32'h0};
	assign cpu0_wr_o = wr_q[0];
	assign cpu0_addr_o = a_q[0];
	assign cpu0_wdata_o = d_q[0];
	assign cpu1_wr_o = wr_q[1];
	assign cpu1_addr_o = a_q[1];
	assign cpu1_wdata_o = d_q[1];
	// ---------------------------------------------------------------
	// write cycle
	// ---------------------------------------------------------------
	// each write is a lone uncached strobe, never a burst or a line fill
	task automatic wr(input int c, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		#1;
		wr_q[c] = 1'b1;
		a_q[c] = a;
		d_q[c] = d;
		@(posedge clk_sys_i);
		#1;
		wr_q[c] = 1'b0;
		a_q[c] = ~a; // stale lines must not look valid
		d_q[c] = ~d;
	endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Purpose: self-checking bench for the interrupt router
// Assumes: inputs change 1 ns after the rising edge
// Notes: expected values follow from reset values and register writes
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dcir_pkg::*;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic legacy_irq_i = 1'b0;
	logic c0_wr, c1_wr;
	logic [31:0] c0_a, c0_d, c1_a, c1_d;
	logic [1:0] legacy_irq_o, ipi_o;
	logic alt_cpu_type_o, mp_enable_o;
	logic [3:0] base_nibble_o;
	int mismatches = 0;
	int check_count = 0;
	always #25 clk_sys_i = ~clk_sys_i;
	dcir_cpu_model HOST (.clk_sys_i(clk_sys_i), .cpu0_wr_o(c0_wr), .cpu0_addr_o(c0_a),
		.cpu0_wdata_o(c0_d), .cpu1_wr_o(c1_wr), .cpu1_addr_o(c1_a), .cpu1_wdata_o(c1_d));
	dcir_router DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .cpu0_wr_i(c0_wr),
		.cpu0_addr_i(c0_a), .cpu0_wdata_i(c0_d), .cpu1_wr_i(c1_wr), .cpu1_addr_i(c1_a),
		.cpu1_wdata_i(c1_d), .legacy_irq_i(legacy_irq_i), .legacy_irq_o(legacy_irq_o),
		.ipi_o(ipi_o), .alt_cpu_type_o(alt_cpu_type_o), .mp_enable_o(mp_enable_o),
		.base_nibble_o(base_nibble_o));
	// ---------------------------------------------------------------
	// helper tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic do_reset();
		sys_rst_i = 1'b1;
		repeat (12) @(posedge clk_sys_i);
		#1;
		sys_rst_i = 1'b0;
	endtask
	// write through a core; nib is the top address digit used
	task automatic w(input int c, input logic [3:0] nib, input logic [27:0] off,
		input logic [31:0] d);
		HOST.wr(c, {nib, off}, d);
	endtask
	// one legacy request, delivery pulse seen the cycle after it is taken
	task automatic irq(input logic [1:0] exp);
		@(posedge clk_sys_i);
		#1;
		legacy_irq_i = 1'b1;
		@(posedge clk_sys_i);
		#1;
		legacy_irq_i = 1'b0;
		chk({2'b00, legacy_irq_o}, {2'b00, exp});
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// test sequence
	// ---------------------------------------------------------------
	initial begin
		do_reset();
		chk(base_nibble_o, 4'hf);
		chk({3'b000, mp_enable_o}, 4'h0);
		chk({3'b000, alt_cpu_type_o}, 4'h0);
		irq(2'b01);
		w(0, 4'hf, DCIR_OFF_IPI, 32'h1);
		chk({2'b00, ipi_o}, 4'h0);
		$display("test reset_values done");
		w(0, 4'hf, DCIR_OFF_MPEN, 32'hfffffffe);
		chk({3'b000, mp_enable_o}, 4'h0);
		w(1, 4'hf, DCIR_OFF_MPEN, 32'h1);
		chk({3'b000, mp_enable_o}, 4'h1);
		w(0, 4'hf, DCIR_OFF_ALTCPU, 32'h1);
		chk({3'b000, alt_cpu_type_o}, 4'h1);
		w(1, 4'hf, DCIR_OFF_IPI, 32'h0);
		chk({2'b00, ipi_o}, 4'h1);
		w(0, 4'hf, DCIR_OFF_IPI, 32'hffffffff);
		chk({2'b00, ipi_o}, 4'h2);
		$display("test ipi done");
		w(0, 4'hf, DCIR_OFF_MASK, 32'h1);
		irq(2'b00);
		w(1, 4'hf, DCIR_OFF_MASK, 32'h0);
		irq(2'b00);
		w(0, 4'hf, DCIR_OFF_MASK, 32'h0);
		irq(2'b01);
		$display("test mask done");
		// second reset puts the alternation back on the first core
		do_reset();
		w(1, 4'hf, DCIR_OFF_MPEN, 32'h1);
		w(1, 4'hf, DCIR_OFF_MASK, 32'h0);
		w(0, 4'hf, DCIR_OFF_TOGGLE, 32'h1);
		irq(2'b01);
		w(0, 4'hf, DCIR_OFF_IPI, 32'h0);
		irq(2'b10);
		irq(2'b01);
		w(1, 4'hf, DCIR_OFF_TOGGLE, 32'h0);
		irq(2'b01);
		irq(2'b01);
		$display("test toggle done");
		w(0, 4'hf, DCIR_OFF_BASE, 32'hfffffff5);
		chk(base_nibble_o, 4'h5);
		w(0, 4'hf, DCIR_OFF_MPEN, 32'h0);
		chk({3'b000, mp_enable_o}, 4'h1);
		w(0, 4'h5, DCIR_OFF_MPEN, 32'h0);
		chk({3'b000, mp_enable_o}, 4'h0);
		w(1, 4'h5, DCIR_OFF_IPI, 32'h0);
		chk({2'b00, ipi_o}, 4'h0);
		$display("test base done");
		// toggle set while mp is off must not alternate; the turn then resumes
		w(1, 4'h5, DCIR_OFF_TOGGLE, 32'h1);
		irq(2'b01);
		irq(2'b01);
		w(0, 4'h5, DCIR_OFF_MPEN, 32'h1);
		w(1, 4'h5, DCIR_OFF_MASK, 32'h1);
		irq(2'b00);
		irq(2'b01);
		irq(2'b00);
		$display("test mp_off done");
		end_sim();
	end
endmodule
`default_nettype wire
